// >>> hw/bcs_pkg.sv
// shared types and constants of the branch, call and skip execution unit
`default_nettype none
package bcs_pkg;
    // program counter width in words
    localparam int PC_W = 16;
    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // cycle counts per instruction class
    localparam logic [2:0] CYC_ONE      = 3'h1;
    localparam logic [2:0] CYC_CALL_ABS = 3'h4;
    localparam logic [2:0] CYC_CALL_REL = 3'h3;
    localparam logic [2:0] CYC_CALL_PTR = 3'h3;
    localparam logic [2:0] CYC_RETURN   = 3'h4;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
    localparam logic [2:0] CYC_IO_BIT   = 3'h2;
    // word distances from the current instruction
    localparam logic [15:0] STEP_ONE   = 16'h0001;
    localparam logic [15:0] STEP_TWO   = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;
    // register port offsets
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_PC_LO  = 2'h1;
    localparam logic [1:0] REG_PC_HI  = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    // control fields and reset values
    localparam int          CTRL_EN_BIT = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h01;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    // status register layout: bit 7 busy, bits 4:0 last opcode
    localparam int STAT_BUSY_BIT = 7;
    // operation codes handed over by the decoder
    typedef enum logic [4:0] {
        OP_NOP          = 5'h00,
        OP_CALL_ABS     = 5'h01,
        OP_CALL_REL     = 5'h02,
        OP_CALL_PTR     = 5'h03,
        OP_SUB_RETURN   = 5'h04,
        OP_IRQ_RETURN   = 5'h05,
        OP_CMP_SKIP_EQ  = 5'h06,
        OP_CMP_REGS     = 5'h07,
        OP_CMP_BORROW   = 5'h08,
        OP_CMP_IMM      = 5'h09,
        OP_SKIP_REG_CLR = 5'h0A,
        OP_SKIP_REG_SET = 5'h0B,
        OP_SKIP_IO_CLR  = 5'h0C,
        OP_SKIP_IO_SET  = 5'h0D,
        OP_BR_FLAG_SET  = 5'h0E,
        OP_BR_FLAG_CLR  = 5'h0F,
        OP_IO_BIT_SET   = 5'h10,
        OP_IO_BIT_CLR   = 5'h11
    } bcs_op_t;
    // one decoded instruction with its operands
    typedef struct packed {
        bcs_op_t     op;
        logic [7:0]  rd_val;    // destination register contents
        logic [7:0]  src_val;   // source register or immediate
        logic [2:0]  bit_sel;   // bit or flag number
        logic [11:0] offset;    // signed word displacement
        logic [15:0] target;    // absolute target or pointer pair
        logic [5:0]  io_addr;   // i/o register number
        logic [7:0]  io_val;    // current i/o register contents
        logic        next_two;  // following instruction is two words
    } bcs_cmd_t;
    // one i/o write
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } bcs_io_wr_t;
endpackage
`default_nettype wire

// >>> hw/bcs_cond.sv
// condition evaluation for branches and skips
`default_nettype none
module bcs_cond
    import bcs_pkg::*;
(
    // instruction and flags
    input  wire bcs_cmd_t   cmd_in,
    input  wire logic [7:0] flags_in,
    // condition holds
    output logic            take_out
);
    // selected status bit; signed test rebuilt from n and v
    wire       nv_sign = flags_in[FLAG_N] ^ flags_in[FLAG_V];
    // zero, negative, carry, half, t, overflow and interrupt flags all read here
    wire       flag_bit = (cmd_in.bit_sel == 3'(FLAG_S)) ? nv_sign
                        : flags_in[cmd_in.bit_sel];
    wire       reg_bit  = cmd_in.src_val[cmd_in.bit_sel];
    wire       io_bit   = cmd_in.io_val[cmd_in.bit_sel];
    wire       equal    = cmd_in.rd_val == cmd_in.src_val;

    // per opcode condition select
    always_comb begin
        case (cmd_in.op)
            OP_CMP_SKIP_EQ:  take_out = equal;
            OP_SKIP_REG_CLR: take_out = !reg_bit;
            OP_SKIP_REG_SET: take_out = reg_bit;
            OP_SKIP_IO_CLR:  take_out = !io_bit;
            OP_SKIP_IO_SET:  take_out = io_bit;
            OP_BR_FLAG_SET:  take_out = flag_bit;
            OP_BR_FLAG_CLR:  take_out = !flag_bit;
            default:         take_out = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> hw/bcs_cmp.sv
// compare subtraction and its flags, no result written anywhere
`default_nettype none
module bcs_cmp
    import bcs_pkg::*;
(
    // operands
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       carry_in,
    input  wire logic       zero_in,
    input  wire logic       chain_in,   // carry form: subtract carry, keep zero
    // flags: c z n v s h, upper bits zero
    output logic [7:0]      flags_out
);
    wire       cin = chain_in & carry_in;
    wire [7:0] res = a_in - b_in - {7'h00, cin};
    // borrow out of bit 7 and bit 3
    wire c7 = (~a_in[7] & b_in[7]) | (b_in[7] & res[7]) | (res[7] & ~a_in[7]);
    wire c3 = (~a_in[3] & b_in[3]) | (b_in[3] & res[3]) | (res[3] & ~a_in[3]);
    wire ov = (a_in[7] & ~b_in[7] & ~res[7]) | (~a_in[7] & b_in[7] & res[7]);
    // carry form only clears zero, so multi-byte compares chain
    wire zf = (res == 8'h00) & (chain_in ? zero_in : 1'b1);

    always_comb begin
        flags_out         = 8'h00;
        flags_out[FLAG_C] = c7;
        flags_out[FLAG_Z] = zf;
        flags_out[FLAG_N] = res[7];
        flags_out[FLAG_V] = ov;
        flags_out[FLAG_S] = res[7] ^ ov;
        flags_out[FLAG_H] = c3;
    end
endmodule
`default_nettype wire

// >>> hw/bcs_exec.sv
// control-flow execution unit: calls, returns, compares, skips, branches, i/o bits
// Functional notes
// - calls: absolute 4, relative 3, pointer 3
// - equal compare skips next, 1/2/3 cycles
// - compares set flags only, one cycle
// - register bit test skips, 1/2/3 cycles
// - i/o bit test skips, 1/2/3 cycles
// - flag branch: taken target pc+offset+1
// - carry branches test carry flag
// - signed branches test n xor v
// - half-carry branches test half-carry flag
// - transfer branches test t flag
// - overflow branches test v flag
// - interrupt branches test global enable
// - i/o bit set/clear, two cycles
`default_nettype none
module bcs_exec
    import bcs_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       ce_in,
    // instruction issue
    input  wire logic       issue_in,
    input  wire bcs_cmd_t   cmd_in,
    output logic            ready_out,
    // status flags
    input  wire logic [7:0] flags_in,
    output logic [7:0]      flags_out,
    output logic            flags_we_out,
    // data stack
    output logic            push_out,
    output logic [15:0]     push_data_out,
    output logic            pop_out,
    input  wire logic [15:0] stack_data_in,
    // i/o space
    output logic            io_we_out,
    output bcs_io_wr_t      io_wr_out,
    // program counter
    output logic [15:0]     pc_out,
    output logic            done_out,
    // register port
    input  wire logic [1:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out
);
    // sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } bcs_state_t;

    bcs_state_t  state;          // idle or counting
    logic [2:0]  cnt;            // cycles still to run
    logic [7:0]  ctrl;           // control register
    logic [4:0]  last_op;        // last accepted opcode
    logic [15:0] pend_pc;        // target held while busy
    logic [7:0]  pend_flags;     // flag result held while busy
    logic        pend_flags_we;  // flag write pending
    logic        pend_io_we;     // i/o write pending
    bcs_io_wr_t  pend_io;        // i/o write held while busy
    logic        pend_pop;       // target comes from the stack
    logic        pend_ie_set;    // interrupt enable to be set

    // decoded instruction class, reused by several terms
    function automatic logic is_skip(input bcs_op_t op);
        is_skip = (op == OP_CMP_SKIP_EQ) || (op == OP_SKIP_REG_CLR) || (op == OP_SKIP_REG_SET)
               || (op == OP_SKIP_IO_CLR) || (op == OP_SKIP_IO_SET);
    endfunction

    function automatic logic is_branch(input bcs_op_t op);
        is_branch = (op == OP_BR_FLAG_SET) || (op == OP_BR_FLAG_CLR);
    endfunction

    function automatic logic is_cmp(input bcs_op_t op);
        is_cmp = (op == OP_CMP_REGS) || (op == OP_CMP_BORROW) || (op == OP_CMP_IMM);
    endfunction

    function automatic logic is_call(input bcs_op_t op);
        is_call = (op == OP_CALL_ABS) || (op == OP_CALL_REL) || (op == OP_CALL_PTR);
    endfunction

    // condition and compare helpers
    wire       take;
    wire [7:0] cmp_flags;

    bcs_cond u_cond (
        .cmd_in   (cmd_in),
        .flags_in (flags_in),
        .take_out (take)
    );

    bcs_cmp u_cmp (
        .a_in      (cmd_in.rd_val),
        .b_in      (cmd_in.src_val),
        .carry_in  (flags_in[FLAG_C]),
        .zero_in   (flags_in[FLAG_Z]),
        .chain_in  (cmd_in.op == OP_CMP_BORROW),
        .flags_out (cmp_flags)
    );

    // accepted only when enabled and idle; ce low freezes everything
    wire accept = ce_in && issue_in && ready_out && ctrl[CTRL_EN_BIT];
    wire op_skip   = is_skip(cmd_in.op);
    wire op_branch = is_branch(cmd_in.op);
    wire op_cmp    = is_cmp(cmd_in.op);
    wire op_call   = is_call(cmd_in.op);
    wire op_ret    = (cmd_in.op == OP_SUB_RETURN) || (cmd_in.op == OP_IRQ_RETURN);
    wire op_io     = (cmd_in.op == OP_IO_BIT_SET) || (cmd_in.op == OP_IO_BIT_CLR);

    // address arithmetic; displacement sign-extended so targets go both ways
    wire [15:0] disp       = {{4{cmd_in.offset[11]}}, cmd_in.offset};
    wire [15:0] rel_target = pc_out + disp + STEP_ONE;
    wire [15:0] pc_plus1   = pc_out + STEP_ONE;
    wire [15:0] skip_dist  = cmd_in.next_two ? STEP_THREE : STEP_TWO;
    wire [15:0] skip_tgt   = pc_out + skip_dist;
    // the absolute call is two words long, so it returns two words on
    wire [15:0] link_addr  = (cmd_in.op == OP_CALL_ABS) ? pc_out + STEP_TWO : pc_plus1;

    // target of the accepted instruction
    wire [15:0] next_target =
        (cmd_in.op == OP_CALL_ABS)    ? cmd_in.target :
        (cmd_in.op == OP_CALL_REL)    ? rel_target :
        (cmd_in.op == OP_CALL_PTR)    ? cmd_in.target :
        ((op_branch || op_skip) && take) ? (op_skip ? skip_tgt : rel_target)
                                      : pc_plus1;

    // cycles of the accepted instruction
    wire [2:0] skip_cyc = cmd_in.next_two ? CYC_SKIP_TWO : CYC_SKIP_ONE;
    wire [2:0] next_cycles =
        (cmd_in.op == OP_CALL_ABS) ? CYC_CALL_ABS :
        (cmd_in.op == OP_CALL_REL) ? CYC_CALL_REL :
        (cmd_in.op == OP_CALL_PTR) ? CYC_CALL_PTR :
        op_ret                     ? CYC_RETURN :
        op_io                      ? CYC_IO_BIT :
        (op_skip && take)          ? skip_cyc :
        (op_branch && take)        ? CYC_BR_TAKEN :
                                     CYC_ONE;

    // i/o read-modify-write, other bits kept
    wire [7:0] bit_mask = 8'h01 << cmd_in.bit_sel;
    wire [7:0] io_new   = (cmd_in.op == OP_IO_BIT_SET) ? (cmd_in.io_val | bit_mask)
                                                       : (cmd_in.io_val & ~bit_mask);

    // compare keeps t and i, replaces the arithmetic flags
    wire [7:0] keep_mask  = 8'h00 | (8'h01 << FLAG_T) | (8'h01 << FLAG_I);
    wire [7:0] cmp_merged = (flags_in & keep_mask) | cmp_flags;

    // final cycle of a multi-cycle instruction
    wire finish_busy = (state == ST_BUSY) && (cnt == CYC_ONE);
    wire one_cycle   = accept && (next_cycles == CYC_ONE);

    // register read mux
    wire [7:0] status_val = {(state == ST_BUSY), 2'h0, last_op};
    wire [7:0] read_val =
        (reg_addr_in == REG_CTRL)   ? ctrl :
        (reg_addr_in == REG_PC_LO)  ? pc_out[7:0] :
        (reg_addr_in == REG_PC_HI)  ? pc_out[15:8] :
                                      status_val;
    // pc writes from software only while idle, never over an accept
    wire pc_wr_ok = reg_wr_in && (state == ST_IDLE) && !accept;

    // sequencer: idle takes an instruction, busy counts down
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state     <= ST_IDLE;
            cnt       <= 3'h0;
            ready_out <= 1'b0;
        end else if (ce_in) begin
            if (accept && !one_cycle) begin
                state     <= ST_BUSY;
                cnt       <= next_cycles - CYC_ONE;
                ready_out <= 1'b0;
            end else if (finish_busy) begin
                state     <= ST_IDLE;
                cnt       <= 3'h0;
                ready_out <= 1'b1;
            end else if (state == ST_BUSY) begin
                cnt <= cnt - CYC_ONE;
            end else begin
                ready_out <= 1'b1;
            end
        end
    end

    // pending results captured at accept
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_pc       <= PC_RESET;
            pend_flags    <= 8'h00;
            pend_flags_we <= 1'b0;
            pend_io_we    <= 1'b0;
            pend_io       <= '0;
            pend_pop      <= 1'b0;
            pend_ie_set   <= 1'b0;
        end else if (ce_in && accept) begin
            pend_pc       <= next_target;
            pend_flags    <= cmp_merged;
            pend_flags_we <= op_cmp;
            pend_io_we    <= op_io;
            pend_io       <= '{addr: cmd_in.io_addr, data: io_new};
            pend_pop      <= op_ret;
            pend_ie_set   <= (cmd_in.op == OP_IRQ_RETURN);
        end
    end

    // stack strobes: push the return address, or pop, right after accept
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            push_out      <= 1'b0;
            push_data_out <= 16'h0000;
            pop_out       <= 1'b0;
        end else if (ce_in) begin
            push_out <= accept && op_call;
            pop_out  <= accept && op_ret;
            if (accept && op_call) begin
                push_data_out <= link_addr;
            end
        end
    end

    // completion: pc, flags and i/o write all land with done
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_out       <= PC_RESET;
            done_out     <= 1'b0;
            flags_out    <= 8'h00;
            flags_we_out <= 1'b0;
            io_we_out    <= 1'b0;
            io_wr_out    <= '0;
        end else if (ce_in) begin
            done_out     <= one_cycle || finish_busy;
            flags_we_out <= 1'b0;
            io_we_out    <= 1'b0;
            if (one_cycle) begin
                pc_out       <= next_target;
                flags_out    <= cmp_merged;
                flags_we_out <= op_cmp;
            end else if (finish_busy) begin
                // return address is stable once the pop has been seen
                pc_out       <= pend_pop ? stack_data_in : pend_pc;
                flags_out    <= pend_ie_set ? (flags_in | (8'h01 << FLAG_I)) : pend_flags;
                flags_we_out <= pend_flags_we || pend_ie_set;
                io_we_out    <= pend_io_we;
                io_wr_out    <= pend_io;
            end else if (pc_wr_ok && (reg_addr_in == REG_PC_LO)) begin
                pc_out[7:0]  <= reg_wdata_in;
            end else if (pc_wr_ok && (reg_addr_in == REG_PC_HI)) begin
                pc_out[15:8] <= reg_wdata_in;
            end
        end
    end

    // control and status registers, read data one cycle after the strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl          <= CTRL_RESET;
            last_op       <= 5'h00;
            reg_rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (reg_wr_in && (reg_addr_in == REG_CTRL)) begin
                ctrl <= reg_wdata_in;
            end
            if (accept) begin
                last_op <= cmd_in.op;
            end
            reg_rdata_out <= reg_rd_in ? read_val : 8'h00;
        end
    end

    // checks, all in the core clock domain
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in || !ce_in);

    sequence s_wait1_done;
        !done_out ##1 done_out;
    endsequence

    sequence s_wait2_done;
        !done_out ##1 !done_out ##1 done_out;
    endsequence

    a_call_abs_time: assert property (
        accept && cmd_in.op == OP_CALL_ABS
            |-> ##3 s_wait1_done ##0 pc_out == $past(cmd_in.target, 4))
        else $error("absolute call not done in four cycles");

    a_call_rel_target: assert property (
        accept && cmd_in.op == OP_CALL_REL |-> ##1 s_wait2_done ##0 pc_out == $past(rel_target, 3))
        else $error("relative call target or timing wrong");

    a_cmp_flags_only: assert property (
        accept && op_cmp |-> ##1 done_out && flags_we_out && !io_we_out
                              && flags_out == $past(cmp_merged))
        else $error("compare did not update flags in one cycle");

    a_branch_not_taken: assert property (
        accept && op_branch && !take |-> ##1 done_out && pc_out == $past(pc_plus1))
        else $error("untaken branch not one cycle");

    a_branch_taken: assert property (
        accept && op_branch && take |-> ##1 s_wait1_done ##0 pc_out == $past(rel_target, 2))
        else $error("taken branch target or timing wrong");

    a_skip_two_word: assert property (
        accept && op_skip && take && cmd_in.next_two
            |-> ##1 s_wait2_done ##0 pc_out == $past(pc_out, 3) + STEP_THREE)
        else $error("skip over two-word instruction wrong");

    a_io_bit_write: assert property (
        accept && op_io |-> ##1 s_wait1_done ##0 io_we_out && io_wr_out.data == $past(io_new, 2))
        else $error("i/o bit write wrong");

    a_return_sets_irq: assert property (
        accept && cmd_in.op == OP_IRQ_RETURN
            |-> ##1 pop_out ##3 done_out && flags_we_out && flags_out[FLAG_I])
        else $error("interrupt return did not set enable");

    a_call_pushes: assert property (
        accept && op_call |-> ##1 push_out && push_data_out == $past(link_addr))
        else $error("call did not push return address");

    a_signed_branch: assert property (
        accept && op_branch && cmd_in.bit_sel == 3'(FLAG_S)
            |-> take == ((flags_in[FLAG_N] ^ flags_in[FLAG_V]) == (cmd_in.op == OP_BR_FLAG_SET)))
        else $error("signed branch condition wrong");

    // untaken skip moves on by one word in a single cycle
    a_skip_untaken: assert property (
        accept && op_skip && !take |-> ##1 done_out && pc_out == $past(pc_plus1))
        else $error("untaken skip not one cycle");

    // pointer call lands on the pointer pair after three cycles
    a_call_ptr_target: assert property (
        accept && cmd_in.op == OP_CALL_PTR
            |-> ##1 s_wait2_done ##0 pc_out == $past(cmd_in.target, 3))
        else $error("pointer call target or timing wrong");

    // a plain return takes the popped word, never the held target
    a_return_pops: assert property (
        accept && cmd_in.op == OP_SUB_RETURN
            |-> ##1 pop_out ##3 done_out && pc_out == $past(stack_data_in))
        else $error("return did not restore popped address");
endmodule
`default_nettype wire

// >>> test/bcs_stack_model.sv
// data stack model on the far side of the execution unit
`default_nettype none
module bcs_stack_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // stack requests from the unit
    input  wire logic        push_in,
    input  wire logic [15:0] push_data_in,
    input  wire logic        pop_in,
    input  wire logic        done_in,
    // popped word
    output logic [15:0]      pop_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [8]; // shallow, bench nests one call deep
    logic [2:0]  sp;      // next free slot
    logic [15:0] held;    // word on show
    logic        valid;   // within the hold window
    // push, pop, and the window from pop to done
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sp <= 3'h0;
            valid <= 1'b0;
            held <= 16'h0000;
        end else if (push_in) begin
            mem[sp] <= push_data_in;
            sp <= sp + 3'h1;
        end else if (pop_in) begin
            held <= mem[sp - 3'h1];
            sp <= sp - 3'h1;
            valid <= 1'b1;
        end else if (done_in) begin
            valid <= 1'b0;
        end
    end
    // outside the window show the inverse, so a late read never passes
    assign pop_data_out = valid ? held : ~held;
endmodule
`default_nettype wire

// >>> test/bcs_exec_tb_top.sv
// self-checking bench for the control-flow execution unit
`default_nettype none
module bcs_exec_tb_top
    import bcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // design ports
    logic        clk_in, reset_n_in, ce_in, issue_in, ready_out, done_out;
    logic        flags_we_out, push_out, pop_out, io_we_out, reg_wr_in, reg_rd_in;
    logic [7:0]  flags_in, flags_out, reg_wdata_in, reg_rdata_out, v;
    logic [15:0] push_data_out, stack_data_in, pc_out, pc, r;
    logic [1:0]  reg_addr_in;
    bcs_cmd_t    cmd_in, c;
    bcs_io_wr_t  io_wr_out;
    // bench state
    int          err_count, comparisons, i;
    bcs_op_t     sk [5];
    bcs_exec DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .issue_in(issue_in), .cmd_in(cmd_in), .ready_out(ready_out), .flags_in(flags_in),
        .flags_out(flags_out), .flags_we_out(flags_we_out), .push_out(push_out),
        .push_data_out(push_data_out), .pop_out(pop_out), .stack_data_in(stack_data_in),
        .io_we_out(io_we_out), .io_wr_out(io_wr_out), .pc_out(pc_out), .done_out(done_out),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
    bcs_stack_model stack (.clk_in(clk_in), .reset_n_in(reset_n_in), .push_in(push_out),
        .push_data_in(push_data_out), .pop_in(pop_out), .done_in(done_out),
        .pop_data_out(stack_data_in));
    // 50 ns clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // closing report
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one comparison, four-state exact
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    // register write, one strobe cycle
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // register read, data looked at in the following cycle only
    task automatic reg_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("reg", {8'h00, e}, {8'h00, reg_rdata_out});
    endtask
    // issue command c, count cycles to done, bounded wait
    task automatic run(input logic [7:0] f, input logic [2:0] cyc, input logic [15:0] pe);
        logic [2:0] n;
        n = 3'h1; // the accepting cycle counts as the first
        @(posedge clk_in);
        issue_in <= 1'b1;
        cmd_in <= c;
        flags_in <= f;
        @(posedge clk_in);
        issue_in <= 1'b0;
        #1;
        while (done_out !== 1'b1 && n < 3'h6) begin
            @(posedge clk_in);
            #1;
            n = n + 3'h1;
        end
        if (done_out !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        chk("cycles", {13'h0000, cyc}, {13'h0000, n});
        chk("pc", pe, pc_out);
        chk("ready", 16'h0001, {15'h0000, ready_out});
        pc = pe;
    endtask
    // main sequence
    initial begin
        {reset_n_in, issue_in, reg_wr_in, reg_rd_in} = 4'h0;
        {flags_in, reg_wdata_in, reg_addr_in} = 18'h00000;
        ce_in = 1'b1;
        cmd_in = '0;
        c = '0;
        err_count = 0;
        comparisons = 0;
        sk = '{OP_CMP_SKIP_EQ, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET};
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        reg_chk(REG_CTRL, 8'h01);
        reg_wr(REG_PC_HI, 8'h01);
        reg_chk(REG_PC_HI, 8'h01);
        pc = 16'h0100;
        // each flag: set-taken, clear-untaken, clear-taken; s selects n xor v
        c.offset = 12'hFFE;
        for (i = 0; i < 8; i++) begin
            v = (i == 4) ? 8'h04 : 8'h01 << i;
            c.bit_sel = i[2:0];
            c.op = OP_BR_FLAG_SET;
            run(v, CYC_BR_TAKEN, pc - STEP_ONE);
            c.op = OP_BR_FLAG_CLR;
            run(v, CYC_ONE, pc + STEP_ONE);
            run(8'h00, CYC_BR_TAKEN, pc - STEP_ONE);
        end
        // calls and returns, stack round trip
        c = '0;
        c.op = OP_CALL_REL;
        c.offset = 12'h010;
        r = pc + STEP_ONE;
        run(8'h00, CYC_CALL_REL, pc + 16'h0011);
        c.op = OP_SUB_RETURN;
        run(8'h00, CYC_RETURN, r);
        c.op = OP_CALL_ABS;
        c.target = 16'h0200;
        r = pc + STEP_TWO;
        run(8'h00, CYC_CALL_ABS, 16'h0200);
        c.op = OP_IRQ_RETURN;
        run(8'h00, CYC_RETURN, r);
        chk("flags", 16'h0080, {8'h00, flags_out});
        c.op = OP_CALL_PTR;
        run(8'h00, CYC_CALL_PTR, 16'h0200);
        // skips over one word, two words, and no skip
        c = '0;
        c.bit_sel = 3'h2;
        for (i = 0; i < 5; i++) begin
            v = (i == 2 || i == 4) ? 8'hFF : 8'h00;
            c.op = sk[i];
            {c.rd_val, c.src_val, c.io_val} = {v, v, v};
            c.next_two = 1'b0;
            run(8'h00, CYC_SKIP_ONE, pc + STEP_TWO);
            c.next_two = 1'b1;
            run(8'h00, CYC_SKIP_TWO, pc + STEP_THREE);
            {c.rd_val, c.src_val, c.io_val} = {(i == 0) ? v : ~v, ~v, ~v};
            run(8'h00, CYC_ONE, pc + STEP_ONE);
        end
        // 03 minus 05: c n s h set, t and i kept
        c.rd_val = 8'h03;
        c.src_val = 8'h05;
        for (i = 0; i < 3; i++) begin
            c.op = (i == 0) ? OP_CMP_REGS : (i == 1) ? OP_CMP_BORROW : OP_CMP_IMM;
            run(8'hC0, CYC_ONE, pc + STEP_ONE);
            chk("flags", 16'h01F5, {7'h00, flags_we_out, flags_out});
        end
        // i/o bit set then clear
        c.op = OP_IO_BIT_SET;
        c.io_addr = 6'h15;
        c.bit_sel = 3'h3;
        c.io_val = 8'h00;
        run(8'h00, CYC_IO_BIT, pc + STEP_ONE);
        chk("io", {2'h2, 6'h15, 8'h08}, {io_we_out, 1'b0, io_wr_out});
        c.op = OP_IO_BIT_CLR;
        c.io_val = 8'hFF;
        run(8'h00, CYC_IO_BIT, pc + STEP_ONE);
        chk("io", {2'h2, 6'h15, 8'hF7}, {io_we_out, 1'b0, io_wr_out});
        // status is read-only: last opcode, not busy
        reg_wr(REG_STATUS, 8'h00);
        reg_chk(REG_STATUS, 8'h11);
        print_verdict();
    end
endmodule
`default_nettype wire
